// ==== susp_seq_pkg.sv ====
package susp_seq_pkg;
    // core clock and tick timing
    localparam int CORE_CLK_HZ = 10_000_000;
    localparam int TICK_US = 32;
    localparam int TICK_CYCLES = (TICK_US * CORE_CLK_HZ) / 1_000_000;
    localparam int MS_TICKS = (1000 + TICK_US - 1) / TICK_US;
    localparam int POWER_SETTLE_MS = 1;
    localparam int PLL_LOCK_MS = 16;
    localparam int STEP_TICKS = 1;
    localparam int RELEASE_TICKS = 2;
    localparam int TICK_W = 16;
    localparam int MS_W = 8;

    typedef enum logic [4:0] {
        ST_ON,
        ST_HALT_REQ,
        ST_WAIT_GRANT,
        ST_SLEEP,
        ST_STATUS,
        ST_CLK_STOP,
        ST_PLANE_OFF,
        ST_SUSPENDED,
        ST_RESUME_WAIT,
        ST_PLANES_ON,
        ST_WAIT_GOOD,
        ST_CLK_ASSERT,
        ST_CLK_LOCK,
        ST_STATUS_WAIT,
        ST_PCI_RELEASE,
        ST_CPU_RELEASE,
        ST_CLK_FREE
    } seq_state_t;

    typedef enum logic [1:0] {
        MODE_RAM,
        MODE_DISK,
        MODE_OFF
    } susp_mode_t;

    // pins toward clock synth, supplies and processor
    typedef struct packed {
        logic [2:0] powerPlaneCtl;
        logic [1:0] suspendStateOut;
        logic pciClockHaltReq;
        logic cpuClockHaltReq;
        logic clockHaltOe;
        logic pciResetOut;
        logic processorResetOut;
        logic processorSleepReq;
        logic processorHaltReq;
        logic suspendClockEn;
    } seq_pins_t;

    // reset value: everything active-low shown as asserted=0
    localparam seq_pins_t PINS_RESET = '{
        powerPlaneCtl: 3'h7,
        suspendStateOut: 2'h3,
        pciClockHaltReq: 1'b1,
        cpuClockHaltReq: 1'b1,
        clockHaltOe: 1'b1,
        pciResetOut: 1'b1,
        processorResetOut: 1'b0,
        processorSleepReq: 1'b1,
        processorHaltReq: 1'b1,
        suspendClockEn: 1'b1
    };
endpackage

// ==== tick_divider.sv ====
`timescale 1ns/100ps
module tick_divider
    import susp_seq_pkg::*;
#(
    parameter int DIVIDE = TICK_CYCLES
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // one-cycle tick enable
    output logic tick
);
    typedef struct packed {
        logic [TICK_W-1:0] count;
        logic tick;
    } div_state_t;

    div_state_t st;
    div_state_t next_st;

    initial
    begin
        if (DIVIDE < 1 || DIVIDE >= (1 << TICK_W))
            $error("tick divider out of range");
    end

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.count == TICK_W'(DIVIDE - 1))
        begin
            next_st.count = '0;
            next_st.tick = 1'b1;
        end
        else
            next_st.count = st.count + 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
endmodule

// ==== susp_clock_gen.sv ====
`timescale 1ns/100ps
module susp_clock_gen
    import susp_seq_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // tick enable and run request
    input wire logic tick,
    input wire logic enable,
    // free-running suspend clock, low when stopped
    output logic suspendClockOut
);
    typedef struct packed {
        logic level;
    } sclk_state_t;

    sclk_state_t st;
    sclk_state_t next_st;

    always_comb
    begin
        next_st = st;
        if (!enable)
            next_st.level = 1'b0;
        else if (tick)
            next_st.level = ~st.level;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign suspendClockOut = st.level;
endmodule

// ==== suspend_resume_sequencer.sv ====
`timescale 1ns/100ps
module suspend_resume_sequencer
    import susp_seq_pkg::*;
#(
    parameter int TICK_DIVIDE = TICK_CYCLES,
    parameter int TICKS_PER_MS = MS_TICKS,
    parameter int SETTLE_MS = POWER_SETTLE_MS,
    parameter int LOCK_MS = PLL_LOCK_MS
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // system requests and status
    input wire logic suspendReq,
    input wire susp_seq_pkg::susp_mode_t suspendMode,
    input wire logic resumeEvent,
    input wire logic power_good_in,
    input wire logic stopGrantDone,
    input wire logic clockControlEn,
    // pins, active-low where the names say so
    output susp_seq_pkg::seq_pins_t pins,
    output logic suspend_clock_out,
    // sequencer status
    output susp_seq_pkg::seq_state_t seqState
);
    typedef struct packed {
        seq_state_t fsm;
        susp_mode_t mode;
        logic [TICK_W-1:0] ticks;
        logic [MS_W-1:0] msCount;
        logic [TICK_W-1:0] msTicks;
        logic goodSeen;
        seq_pins_t pins;
    } seq_regs_t;

    seq_regs_t st;
    seq_regs_t next_st;
    logic tick;

    initial
    begin
        if (TICKS_PER_MS < 1 || TICKS_PER_MS >= (1 << TICK_W))
            $error("ticks per ms out of range");
        if (LOCK_MS < 1 || LOCK_MS >= (1 << MS_W))
            $error("lock time out of range");
        if (SETTLE_MS < 1 || SETTLE_MS > LOCK_MS)
            $error("settle time out of range");
    end

    tick_divider #(.DIVIDE(TICK_DIVIDE)) u_div (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick)
    );

    susp_clock_gen u_sclk (
        .core_clk(core_clk),
        .rst(rst),
        .tick(tick),
        .enable(st.pins.suspendClockEn),
        .suspendClockOut(suspend_clock_out)
    );

    // true once a state has counted n ticks since its counter cleared
    function automatic logic waited(input logic [TICK_W-1:0] t, input int n);
        waited = t >= TICK_W'(n);
    endfunction

    // core power comes back: halts float, resets on, sleep/halt idle
    function automatic seq_pins_t core_up(input seq_pins_t p);
        seq_pins_t q;
        q = p;
        q.clockHaltOe = 1'b0;
        q.pciClockHaltReq = 1'b1;
        q.cpuClockHaltReq = 1'b1;
        q.pciResetOut = 1'b0;
        q.processorResetOut = 1'b1;
        q.processorSleepReq = 1'b1;
        q.processorHaltReq = 1'b1;
        return q;
    endfunction

    always_comb
    begin
        next_st = st;
        // per-state wait counters advance on the tick only
        if (tick)
        begin
            if (st.ticks != '1)
                next_st.ticks = st.ticks + 1'b1;
            // first tick after a clear is partial, it only primes the count
            if (st.msTicks >= TICK_W'(TICKS_PER_MS))
            begin
                next_st.msTicks = TICK_W'(STEP_TICKS);
                if (st.msCount != '1)
                    next_st.msCount = st.msCount + 1'b1;
            end
            else
                next_st.msTicks = st.msTicks + 1'b1;
        end
        unique case (st.fsm)
            ST_ON:
            begin
                if (suspendReq)
                begin
                    next_st.mode = suspendMode;
                    next_st.goodSeen = 1'b0;
                    next_st.fsm = ST_HALT_REQ;
                    next_st.ticks = '0;
                end
            end
            ST_HALT_REQ:
            begin
                // entered off the tick, so one whole tick must pass first
                if (tick && waited(st.ticks, STEP_TICKS))
                begin
                    next_st.pins.processorHaltReq = 1'b0;
                    next_st.fsm = ST_WAIT_GRANT;
                    next_st.ticks = '0;
                end
            end
            ST_WAIT_GRANT:
            begin
                if (stopGrantDone)
                    next_st.goodSeen = 1'b1;
                if (tick && waited(st.ticks, STEP_TICKS - 1)
                    && (st.goodSeen || stopGrantDone))
                begin
                    next_st.pins.processorSleepReq = 1'b0;
                    next_st.goodSeen = 1'b0;
                    next_st.fsm = ST_SLEEP;
                    next_st.ticks = '0;
                end
            end
            ST_SLEEP:
            begin
                if (tick)
                begin
                    next_st.pins.suspendStateOut = 2'h0;
                    next_st.fsm = ST_STATUS;
                end
            end
            ST_STATUS:
            begin
                if (tick)
                begin
                    if (clockControlEn)
                    begin
                        next_st.pins.pciClockHaltReq = 1'b0;
                        next_st.pins.cpuClockHaltReq = 1'b0;
                    end
                    next_st.fsm = ST_CLK_STOP;
                end
            end
            ST_CLK_STOP:
            begin
                if (tick)
                begin
                    if (st.mode == MODE_RAM)
                        next_st.pins.powerPlaneCtl[1:0] = 2'h0;
                    else
                        next_st.pins.powerPlaneCtl = 3'h0;
                    next_st.fsm = ST_PLANE_OFF;
                end
            end
            ST_PLANE_OFF:
            begin
                if (tick)
                begin
                    if (st.mode != MODE_RAM)
                        next_st.pins.suspendClockEn = 1'b0;
                    next_st.fsm = ST_SUSPENDED;
                end
            end
            ST_SUSPENDED:
            begin
                // outputs hold unless power good drops or resume arrives
                if (resumeEvent)
                begin
                    next_st.fsm = ST_RESUME_WAIT;
                    next_st.ticks = '0;
                end
            end
            ST_RESUME_WAIT:
            begin
                if (tick && waited(st.ticks, STEP_TICKS))
                begin
                    if (st.mode == MODE_RAM)
                        next_st.pins.powerPlaneCtl[1:0] = 2'h3;
                    else
                        next_st.pins.powerPlaneCtl = 3'h7;
                    next_st.fsm = ST_PLANES_ON;
                    next_st.ticks = '0;
                    next_st.msCount = '0;
                    next_st.msTicks = '0;
                end
            end
            ST_PLANES_ON:
            begin
                // plane release lets core power return
                next_st.pins = core_up(st.pins);
                next_st.fsm = ST_WAIT_GOOD;
            end
            ST_WAIT_GOOD:
            begin
                // supply holds power good off for its own settle time
                if (power_good_in)
                begin
                    next_st.pins.clockHaltOe = 1'b1;
                    next_st.pins.pciClockHaltReq = 1'b0;
                    next_st.pins.cpuClockHaltReq = 1'b0;
                    next_st.fsm = ST_CLK_ASSERT;
                    next_st.ticks = '0;
                end
            end
            ST_CLK_ASSERT:
            begin
                // a whole tick past power good, counted alongside the lock
                if (waited(st.ticks, STEP_TICKS + 1)
                    && st.msCount >= MS_W'(LOCK_MS))
                begin
                    next_st.pins.pciClockHaltReq = 1'b1;
                    next_st.pins.cpuClockHaltReq = 1'b1;
                    next_st.fsm = ST_CLK_LOCK;
                    next_st.ticks = '0;
                    next_st.msCount = '0;
                    next_st.msTicks = '0;
                end
            end
            ST_CLK_LOCK:
            begin
                if (st.msCount >= MS_W'(SETTLE_MS))
                begin
                    next_st.pins.suspendStateOut = 2'h3;
                    // enabling here lets the clock run at the next tick
                    next_st.pins.suspendClockEn = 1'b1;
                    next_st.fsm = ST_STATUS_WAIT;
                    next_st.ticks = '0;
                end
            end
            ST_STATUS_WAIT:
            begin
                // entered off the tick, so one whole tick must pass first
                if (tick && waited(st.ticks, STEP_TICKS))
                begin
                    next_st.pins.pciResetOut = 1'b1;
                    next_st.fsm = ST_PCI_RELEASE;
                end
            end
            ST_PCI_RELEASE:
            begin
                if (tick)
                begin
                    next_st.pins.processorResetOut = 1'b0;
                    next_st.fsm = ST_CPU_RELEASE;
                end
            end
            ST_CPU_RELEASE:
            begin
                // halts stay fixed until the fourth tick past status release
                if (tick && waited(st.ticks, RELEASE_TICKS))
                    next_st.fsm = ST_CLK_FREE;
            end
            ST_CLK_FREE:
            begin
                next_st.fsm = ST_ON;
            end
        endcase
        // losing power good forces core-up pins in every step except ST_PLANES_ON and ST_WAIT_GOOD, and ST_SUSPENDED from all but ST_SUSPENDED and ST_RESUME_WAIT
        if (!power_good_in && st.fsm != ST_WAIT_GOOD
            && st.fsm != ST_PLANES_ON)
        begin
            next_st.pins = core_up(next_st.pins);
            if (st.fsm != ST_SUSPENDED && st.fsm != ST_RESUME_WAIT)
            begin
                next_st.fsm = ST_SUSPENDED;
                next_st.pins.suspendStateOut = 2'h0;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st <= '0;
            st.fsm <= ST_ON;
            st.mode <= MODE_RAM;
            st.pins <= PINS_RESET;
        end
        else
            st <= next_st;
    end

    assign pins = st.pins;
    assign seqState = st.fsm;

    a_halt_before_sleep: assert property (@(posedge core_clk) disable iff (rst)
        $fell(st.pins.processorSleepReq) |-> !st.pins.processorHaltReq)
        else $error("sleep asserted without halt request");

    a_resets_on_loss: assert property (@(posedge core_clk) disable iff (rst)
        !power_good_in && st.fsm != ST_WAIT_GOOD && st.fsm != ST_PLANES_ON
        |=> st.pins.processorResetOut && !st.pins.pciResetOut
        && !st.pins.clockHaltOe)
        else $error("resets not asserted after power good loss");

    a_pci_before_cpu: assert property (@(posedge core_clk) disable iff (rst)
        $fell(st.pins.processorResetOut) |-> st.pins.pciResetOut
        && $past(st.pins.pciResetOut))
        else $error("processor reset released before pci reset");

    a_status_after_ms: assert property (@(posedge core_clk) disable iff (rst)
        $rose(st.pins.suspendStateOut[0]) && st.fsm == ST_STATUS_WAIT
        |-> $past(st.msCount) >= MS_W'(SETTLE_MS))
        else $error("status released before settle time");

    a_lock_wait: assert property (@(posedge core_clk) disable iff (rst)
        st.fsm == ST_CLK_ASSERT ##1 st.fsm == ST_CLK_LOCK
        |-> st.pins.pciClockHaltReq && $past(st.msCount) >= MS_W'(LOCK_MS))
        else $error("clock halts released before lock time");

    a_halt_clock_ctl: assert property (@(posedge core_clk) disable iff (rst)
        st.fsm == ST_STATUS && tick && !clockControlEn
        |=> st.pins.pciClockHaltReq == $past(st.pins.pciClockHaltReq))
        else $error("clock halt asserted without clock control");

    a_disk_planes: assert property (@(posedge core_clk) disable iff (rst)
        st.fsm == ST_CLK_STOP && tick && st.mode != MODE_RAM && power_good_in
        |=> st.pins.powerPlaneCtl == 3'h0)
        else $error("power planes not all asserted");

    a_sclk_stopped: assert property (@(posedge core_clk) disable iff (rst)
        st.fsm == ST_SUSPENDED && st.mode != MODE_RAM
        |-> ##1 !suspend_clock_out)
        else $error("suspend clock running in disk suspend");
endmodule

// ==== supply_cpu_model.sv ====
`timescale 1ns/100ps
module supply_cpu_model
    import susp_seq_pkg::*;
(
    // clock
    input wire logic core_clk,
    // sequencer pins and scenario controls
    input wire susp_seq_pkg::seq_pins_t pins,
    input wire logic keepPower,
    input wire logic [15:0] pgDelay,
    input wire logic [3:0] grantDelay,
    // supply, processor and clock synthesizer answers
    output logic power_good_in,
    output logic stopGrantDone,
    output logic clocksRunning
);
    logic planesOff;
    logic wasOff = 1'b0;
    logic [15:0] settle = 16'hffff;
    logic [3:0] grantCount = 4'h0;

    initial power_good_in = 1'b1;
    initial stopGrantDone = 1'b0;
    initial clocksRunning = 1'b1;
    assign planesOff = pins.powerPlaneCtl[1:0] === 2'h0;

    always @(posedge core_clk)
    begin
        wasOff <= planesOff;
        if (planesOff !== wasOff)
            settle <= 16'h0000;
        else if (settle != 16'hffff)
            settle <= settle + 16'h0001;
        // the supply decays a little after the planes switch off
        if (planesOff && !keepPower && settle == 16'h0008)
            power_good_in <= 1'b0;
        // good only after the core well has settled for pgDelay cycles
        if (!planesOff && settle == pgDelay)
            power_good_in <= 1'b1;
        if (pins.processorHaltReq === 1'b0 && grantCount != grantDelay)
            grantCount <= grantCount + 4'h1;
        else if (pins.processorHaltReq !== 1'b0)
            grantCount <= 4'h0;
        stopGrantDone <= pins.processorHaltReq === 1'b0 &&
            grantCount == grantDelay;
        // a pci clock is far shorter than a core cycle
        clocksRunning <= !(pins.clockHaltOe === 1'b1 &&
            pins.pciClockHaltReq === 1'b0);
    end
endmodule

// ==== suspend_resume_sequencer_test.sv ====
`timescale 1ns/100ps
module suspend_resume_sequencer_test;
    import susp_seq_pkg::*;
    localparam int TD = 4;
    localparam int TPM = 2;
    localparam int LOCK = 16;
    localparam int SETTLE = 1;
    logic core_clk, rst, suspendReq, resumeEvent, power_good_in;
    logic stopGrantDone, clockControlEn, suspend_clock_out, clocksRunning;
    logic prevSclk, prevPg, prevGrant, keepPower;
    logic [15:0] pgDelay;
    logic [3:0] grantDelay;
    susp_mode_t suspendMode;
    seq_pins_t pins, prevPins, snap;
    seq_state_t seqState;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int tHalt = 0, tSleep = 0, tStat = 0, tClk = 0, tPlane = 0, tSclk = 0;
    int tPci = 0, tCpu = 0, tPg = 0, tGrant = 0, tOe = 0;

    suspend_resume_sequencer #(.TICK_DIVIDE(TD), .TICKS_PER_MS(TPM),
        .SETTLE_MS(SETTLE), .LOCK_MS(LOCK)) dut (.core_clk(core_clk),
        .rst(rst), .suspendReq(suspendReq), .suspendMode(suspendMode),
        .resumeEvent(resumeEvent), .power_good_in(power_good_in),
        .stopGrantDone(stopGrantDone), .clockControlEn(clockControlEn),
        .pins(pins), .suspend_clock_out(suspend_clock_out),
        .seqState(seqState));
    supply_cpu_model supply (.core_clk(core_clk), .pins(pins),
        .keepPower(keepPower), .pgDelay(pgDelay), .grantDelay(grantDelay),
        .power_good_in(power_good_in), .stopGrantDone(stopGrantDone),
        .clocksRunning(clocksRunning));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // change stamps lag one cycle, so only differences are compared
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        prevPins <= pins;
        prevSclk <= suspend_clock_out;
        prevPg <= power_good_in;
        prevGrant <= stopGrantDone;
        if (pins.processorHaltReq !== prevPins.processorHaltReq) tHalt <= cyc;
        if (pins.processorSleepReq !== prevPins.processorSleepReq) tSleep <= cyc;
        if (pins.suspendStateOut !== prevPins.suspendStateOut) tStat <= cyc;
        if (pins.pciClockHaltReq !== prevPins.pciClockHaltReq) tClk <= cyc;
        if (pins.clockHaltOe !== prevPins.clockHaltOe) tOe <= cyc;
        if (pins.powerPlaneCtl !== prevPins.powerPlaneCtl) tPlane <= cyc;
        if (pins.pciResetOut !== prevPins.pciResetOut) tPci <= cyc;
        if (pins.processorResetOut !== prevPins.processorResetOut) tCpu <= cyc;
        if (power_good_in !== prevPg) tPg <= cyc;
        if (stopGrantDone === 1'b1 && prevGrant !== 1'b1) tGrant <= cyc;
        if (suspend_clock_out !== prevSclk && tSclk <= tStat) tSclk <= cyc;
    end

    task automatic step();
        @(posedge core_clk);
        #10;
    endtask

    task automatic chk(input string what, input bit ok,
        input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (!ok)
        begin
            $display("ERROR %s expected %0d seen %0d", what, exp, seen);
            errors++;
        end
    endtask

    task automatic wait_state(input seq_state_t s, input int limit);
        int n;
        n = 0;
        while (seqState !== s && n < limit)
        begin
            step();
            n++;
        end
        chk("state", seqState === s, s, seqState);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic test_reset();
        chk("reset pins", pins === PINS_RESET, PINS_RESET, pins);
        chk("reset sclk", suspend_clock_out === 1'b0, 0, suspend_clock_out);
        resumeEvent = 1'b1;
        step();
        resumeEvent = 1'b0;
        repeat (2 * TD) step();
        // a resume while on must be ignored
        chk("ignored resume", seqState === ST_ON, ST_ON, seqState);
        chk("pins kept", pins === PINS_RESET, PINS_RESET, pins);
        $display("test_reset done");
    endtask

    task automatic test_entry(input susp_mode_t mode, input logic ctl,
        input logic keep, input logic [3:0] grant);
        int tReq;
        int n;
        logic [2:0] plane;
        plane = mode == MODE_RAM ? 3'h4 : 3'h0;
        clockControlEn = ctl;
        keepPower = keep;
        grantDelay = grant;
        suspendMode = mode;
        suspendReq = 1'b1;
        tReq = cyc;
        step();
        suspendReq = 1'b0;
        n = 0;
        while (pins.powerPlaneCtl[1:0] !== 2'h0 && n < 400)
        begin
            step();
            n++;
        end
        step();
        chk("halt", tHalt - tReq >= TD, TD, tHalt - tReq);
        chk("sleep gap", tSleep - tHalt >= TD, TD, tSleep - tHalt);
        chk("sleep grant", tSleep > tGrant, tGrant, tSleep);
        chk("status gap", tStat - tSleep <= TD + 1, TD, tStat - tSleep);
        chk("status", pins.suspendStateOut === 2'h0, 0, pins.suspendStateOut);
        if (ctl)
            chk("halts", tClk - tStat <= TD + 1 && pins.pciClockHaltReq ===
                1'b0 && pins.cpuClockHaltReq === 1'b0, 0, tClk - tStat);
        else
            chk("no halts", pins.pciClockHaltReq === 1'b1 &&
                pins.cpuClockHaltReq === 1'b1, 1, pins.pciClockHaltReq);
        chk("planes", pins.powerPlaneCtl === plane, plane, pins.powerPlaneCtl);
        chk("plane gap", tPlane - tStat <= 2 * TD + 1, TD, tPlane - tStat);
        n = 0;
        repeat (TD + 1) step();
        // outside MODE_RAM the suspend clock stops a tick after the planes; with power kept, all then holds
        snap = pins;
        repeat (3 * TD)
        begin
            step();
            n += suspend_clock_out === 1'b0 ? 0 : 1;
        end
        if (mode != MODE_RAM)
            chk("sclk low", n == 0, 0, n);
        if (keep)
            chk("held", pins === snap && seqState === ST_SUSPENDED,
                snap, pins);
        else
        begin
            chk("pg fell", power_good_in === 1'b0, 0, power_good_in);
            chk("float", pins.clockHaltOe === 1'b0 && pins.pciResetOut ===
                1'b0 && pins.processorResetOut === 1'b1 &&
                pins.processorSleepReq === 1'b1 &&
                pins.processorHaltReq === 1'b1, 1, pins);
            chk("float gap", tCpu - tPg <= TD + 1 && tOe - tPg <= TD + 1,
                TD, tCpu - tPg);
        end
        wait_state(ST_SUSPENDED, 50);
        $display("test_entry done");
    endtask

    task automatic test_resume(input susp_mode_t mode, input logic [15:0] pg);
        int tEv;
        pgDelay = pg;
        resumeEvent = 1'b1;
        tEv = cyc;
        step();
        resumeEvent = 1'b0;
        if (pg > 16'h0040)
        begin
            wait_state(ST_WAIT_GOOD, 100);
            chk("core up", pins.clockHaltOe === 1'b0 && pins.pciResetOut ===
                1'b0 && pins.processorResetOut === 1'b1 &&
                pins.processorSleepReq === 1'b1 &&
                pins.processorHaltReq === 1'b1, 1, pins);
        end
        wait_state(ST_ON, 1500);
        chk("plane gap", tPlane - tEv >= TD, TD, tPlane - tEv);
        chk("planes", pins.powerPlaneCtl === 3'h7, 7, pins.powerPlaneCtl);
        chk("pg to halts", tClk - tPg >= TD, TD, tClk - tPg);
        chk("lock", tClk - tPlane >= LOCK * TPM * TD, LOCK * TPM * TD,
            tClk - tPlane);
        chk("settle", tStat - tClk >= SETTLE * TPM * TD, SETTLE * TPM * TD,
            tStat - tClk);
        chk("status", pins.suspendStateOut === 2'h3, 3, pins.suspendStateOut);
        chk("pci", tPci - tStat >= TD && pins.pciResetOut === 1'b1, TD,
            tPci - tStat);
        chk("cpu", tCpu - tPci >= TD && pins.processorResetOut === 1'b0, TD,
            tCpu - tPci);
        chk("halts fixed", tClk < tStat && pins.pciClockHaltReq === 1'b1,
            tStat, tClk);
        if (mode != MODE_RAM)
            chk("sclk run", tSclk > tStat && tSclk - tStat <= TD + 1, TD,
                tSclk - tStat);
        chk("clocks", clocksRunning === 1'b1, 1, clocksRunning);
        $display("test_resume done");
    endtask

    initial
    begin
        rst = 1'b1;
        suspendReq = 1'b0;
        suspendMode = MODE_RAM;
        resumeEvent = 1'b0;
        clockControlEn = 1'b1;
        keepPower = 1'b0;
        pgDelay = 16'h000a;
        grantDelay = 4'h3;
        repeat (8) @(posedge core_clk);
        #10;
        rst = 1'b0;
        test_reset();
        test_entry(MODE_RAM, 1'b1, 1'b0, 4'h3);
        test_resume(MODE_RAM, 16'h000a);
        test_entry(MODE_DISK, 1'b0, 1'b0, 4'hc);
        test_resume(MODE_DISK, 16'h00c8);
        test_entry(MODE_OFF, 1'b1, 1'b1, 4'h1);
        test_resume(MODE_OFF, 16'h000a);
        stop_test();
    end

    // the whole run needs well under 10000 cycles
    initial
    begin
        #3000000;
        errors++;
        stop_test();
    end
endmodule
